/* core/mcesv_classify.sv */
// sorts local errors into setting, watchdog, stopping, continuable and list
`timescale 1ns/1ps
`include "mcesv_consts.svh"
module mcesv_classify (
   input wire logic [8:0] local_err,
   output logic setting_err,
   output logic wdt_err,
   output logic diag_stop,
   output logic cont_err,
   output logic list_err
);
   assign setting_err = local_err[`MCESV_ERR_SETTING];
   assign wdt_err = local_err[`MCESV_ERR_WDT];
   assign diag_stop = local_err[`MCESV_ERR_DIAG_STOP];
   assign cont_err = |local_err[`MCESV_ERR_SRV_SET:`MCESV_ERR_PROGRAM];
   assign list_err = local_err[`MCESV_ERR_LIST];
endmodule

/* core/mcesv_consts.svh */
// constants for the multi-cpu error supervisor
`ifndef MCESV_CONSTS_SVH
`define MCESV_CONSTS_SVH

`define MCESV_CODE_NONE 16'h0000
`define MCESV_CODE_PEER_HALT 16'h1B58
`define MCESV_CODE_PEER_WARN 16'h1B6C
`define MCESV_CODE_LIST 16'h2710

`define MCESV_ADDR_CTRL 4'h0
`define MCESV_ADDR_STOPALL 4'h1
`define MCESV_ADDR_STATUS 4'h2
`define MCESV_ADDR_ERRCODE 4'h3
`define MCESV_ADDR_ERRCPU 4'h4
`define MCESV_ADDR_OUTPUTS 4'h5
`define MCESV_ADDR_LOCALERR 4'h6

`define MCESV_CTRL_RUN 0
`define MCESV_STOPALL_RESET 4'hF

`define MCESV_ERR_SETTING 0
`define MCESV_ERR_WDT 1
`define MCESV_ERR_DIAG_STOP 2
`define MCESV_ERR_PROGRAM 3
`define MCESV_ERR_MINOR 4
`define MCESV_ERR_MAJOR 5
`define MCESV_ERR_SERVO 6
`define MCESV_ERR_SRV_SET 7
`define MCESV_ERR_LIST 8

`endif

/* core/mcesv_peer_watch.sv */
// watches peers for stop errors and resets
`timescale 1ns/1ps
module mcesv_peer_watch #(
   parameter int NCPU = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [NCPU-1:0] peer_stop,
   input wire logic [NCPU-1:0] peer_in_reset,
   input wire logic [NCPU-1:0] stop_all,
   input wire logic [1:0] self_id,
   input wire logic running,
   output logic halt_evt,
   output logic warn_evt,
   output logic [1:0] evt_cpu
);
   initial begin
      if (NCPU < 2 || NCPU > 4) begin
         $error("NCPU must be 2 to 4");
      end
   end
   logic [NCPU-1:0] prev_stop;
   logic [NCPU-1:0] not_self;
   logic [NCPU-1:0] new_stop;
   logic [NCPU-1:0] halt_src;
   logic [NCPU-1:0] warn_src;
   logic [NCPU-1:0] any_src;
   logic [1:0] first_idx;

   function automatic logic [1:0] low_idx(input logic [NCPU-1:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = NCPU - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      not_self = '1;
      not_self[self_id] = 1'b0;
   end
   assign new_stop = peer_stop & ~prev_stop & not_self;
   assign halt_src = (new_stop & (stop_all | NCPU'(1)))
      | (peer_in_reset & not_self & ~NCPU'(1) & {NCPU{running}});
   assign warn_src = new_stop & ~stop_all & ~NCPU'(1);
   assign any_src = (|halt_src) ? halt_src : warn_src;
   assign first_idx = low_idx(any_src);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_stop <= '0;
         halt_evt <= 1'b0;
         warn_evt <= 1'b0;
         evt_cpu <= 2'h0;
      end else if (ce) begin
         prev_stop <= peer_stop;
         halt_evt <= |halt_src;
         warn_evt <= (|warn_src) & ~(|halt_src);
         evt_cpu <= first_idx;
      end
   end
endmodule

/* core/mcesv_pkg.sv */
// types for the multi-cpu error supervisor
package mcesv_pkg;
   typedef enum logic [1:0] {
      MCESV_IDLE = 2'b00,
      MCESV_RUN = 2'b01,
      MCESV_STOP = 2'b11,
      MCESV_BLOCKED = 2'b10
   } mcesv_state_e;
   typedef logic [15:0] mcesv_code_t;
endpackage

/* core/mcesv_supervisor.sv */
// multi-cpu error supervisor top
//
// Functional notes
// - cpu one stop halts everything with 7000
// - per-cpu stop-all setting, resets to all
// - enabled peer stop raises 7000, halts
// - disabled peer stop raises 7020, continue
// - detecting cpu raises the halt itself
// - only own reset recovers
// - setting error: never run, outputs off
// - watchdog timeout forces outputs off
// - stopping diagnosis error enters stop
// - own stop: ready off, outputs off
// - continuable errors halt program, keep outputs
// - code 10000 flags own error list
// - peer reset other than cpu one while running raises 7000
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mcesv_consts.svh"
module mcesv_supervisor
   import mcesv_pkg::*;
#(
   parameter int NCPU = 4,
   parameter int NOUT = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [1:0] self_id,
   input wire logic [8:0] local_err,
   input wire logic [NCPU-1:0] peer_stop,
   input wire logic [NCPU-1:0] peer_in_reset,
   input wire logic [NOUT-1:0] prog_outputs,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic self_stop,
   output logic controller_ready_flag,
   output logic [NOUT-1:0] actual_output_points,
   output logic program_halt,
   output mcesv_pkg::mcesv_code_t shared_err_code,
   output logic [1:0] shared_err_cpu,
   output logic shared_err_valid
);
   import mcesv_pkg::*;

   initial begin
      if (NOUT < 1 || NOUT > 16) begin
         $error("NOUT must be 1 to 16");
      end
      if (NCPU < 2 || NCPU > 4) begin
         $error("NCPU must be 2 to 4");
      end
      if (`MCESV_ERR_LIST > 8) begin
         $error("error field beyond local_err");
      end
   end

   mcesv_state_e state;
   mcesv_state_e next_state;
   logic run_req;
   logic [NCPU-1:0] stop_all;
   logic [15:0] err_code;
   logic [1:0] err_cpu;
   logic err_valid;
   logic outputs_off;
   logic halt_evt;
   logic warn_evt;
   logic [1:0] evt_cpu;
   logic setting_err;
   logic wdt_err;
   logic diag_stop;
   logic cont_err;
   logic list_err;
   logic wr_ctrl;
   logic wr_stopall;
   logic halted;
   logic stop_now;
   logic [15:0] rd_mux;
   logic running;
   logic rec_halt;
   logic rec_diag;
   logic rec_warn;
   logic rec_list;
   logic rec_set;
   logic [15:0] next_err_code;
   logic [1:0] next_err_cpu;
   logic out_clear;
   logic out_load;
   logic next_ready;
   logic next_self_stop;
   logic [15:0] rd_ctrl;
   logic [15:0] rd_stopall;
   logic [15:0] rd_status;
   logic [15:0] rd_errcpu;
   logic [15:0] rd_outputs;
   logic [15:0] rd_localerr;

   mcesv_peer_watch #(.NCPU(NCPU)) u_watch (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .peer_stop(peer_stop),
      .peer_in_reset(peer_in_reset),
      .stop_all(stop_all),
      .self_id(self_id),
      .running(running),
      .halt_evt(halt_evt),
      .warn_evt(warn_evt),
      .evt_cpu(evt_cpu)
   );

   mcesv_classify u_class (
      .local_err(local_err),
      .setting_err(setting_err),
      .wdt_err(wdt_err),
      .diag_stop(diag_stop),
      .cont_err(cont_err),
      .list_err(list_err)
   );

   // write strobe aimed at one register
   function automatic logic wr_hit(input logic wr, input logic [3:0] a,
         input logic [3:0] t);
      return wr && a == t;
   endfunction

   assign wr_ctrl = wr_hit(reg_wr, reg_addr, `MCESV_ADDR_CTRL);
   assign wr_stopall = wr_hit(reg_wr, reg_addr, `MCESV_ADDR_STOPALL);
   assign halted = state == MCESV_STOP || state == MCESV_BLOCKED;
   assign stop_now = diag_stop | halt_evt;
   assign running = state == MCESV_RUN;

   always_comb begin
      next_state = state;
      case (state)
         MCESV_IDLE: begin
            if (setting_err) begin
               next_state = MCESV_BLOCKED;
            end else if (stop_now) begin
               next_state = MCESV_STOP;
            end else if (run_req) begin
               next_state = MCESV_RUN;
            end
         end
         MCESV_RUN: begin
            if (stop_now) begin
               next_state = MCESV_STOP;
            end else if (!run_req) begin
               next_state = MCESV_IDLE;
            end
         end
         MCESV_STOP: next_state = MCESV_STOP;
         MCESV_BLOCKED: next_state = MCESV_BLOCKED;
         default: next_state = MCESV_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= MCESV_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_req <= 1'b0;
      end else if (ce && wr_ctrl) begin
         run_req <= reg_wdata[`MCESV_CTRL_RUN];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stop_all <= NCPU'(`MCESV_STOPALL_RESET);
      end else if (ce && wr_stopall) begin
         stop_all <= reg_wdata[NCPU-1:0];
      end
   end

   // record code, halt first, list last
   function automatic logic [15:0] stop_code(input logic h, input logic d,
         input logic w, input logic l);
      logic [15:0] c;
      c = `MCESV_CODE_LIST;
      if (h) begin
         c = `MCESV_CODE_PEER_HALT;
      end else if (d) begin
         c = l ? `MCESV_CODE_LIST : `MCESV_CODE_PEER_HALT;
      end else if (w) begin
         c = `MCESV_CODE_PEER_WARN;
      end
      return c;
   endfunction

   assign rec_halt = halt_evt && !halted;
   assign rec_diag = diag_stop && !halted;
   assign rec_warn = warn_evt && !halted;
   assign rec_list = list_err && !err_valid;
   assign rec_set = rec_halt || rec_diag || rec_warn || rec_list;
   assign next_err_code = stop_code(rec_halt, rec_diag, rec_warn, list_err);
   assign next_err_cpu = (rec_warn && !rec_halt && !rec_diag) ? evt_cpu
      : self_id;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_code <= `MCESV_CODE_NONE;
         err_cpu <= 2'h0;
         err_valid <= 1'b0;
      end else if (ce && rec_set) begin
         err_code <= next_err_code;
         err_cpu <= next_err_cpu;
         err_valid <= 1'b1;
      end
   end

   assign outputs_off = halted | wdt_err | setting_err;
   assign out_clear = outputs_off || next_state != MCESV_RUN;
   assign out_load = !out_clear && !cont_err;
   assign next_ready = next_state == MCESV_RUN && !wdt_err && !setting_err;
   assign next_self_stop = next_state == MCESV_STOP;

   // output points, cleared, loaded or held
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         actual_output_points <= '0;
      end else if (ce) begin
         if (out_clear) begin
            actual_output_points <= '0;
         end else if (out_load) begin
            actual_output_points <= prog_outputs;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         controller_ready_flag <= 1'b0;
      end else if (ce) begin
         controller_ready_flag <= next_ready;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         self_stop <= 1'b0;
      end else if (ce) begin
         self_stop <= next_self_stop;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         program_halt <= 1'b0;
      end else if (ce) begin
         program_halt <= cont_err;
      end
   end

   assign shared_err_code = err_code;
   assign shared_err_cpu = err_cpu;
   assign shared_err_valid = err_valid;

   assign rd_ctrl = {15'h0000, run_req};
   assign rd_stopall = 16'(stop_all);
   assign rd_status = {11'h000, err_valid, self_stop, controller_ready_flag,
      state};
   assign rd_errcpu = {14'h0000, err_cpu};
   assign rd_outputs = 16'(actual_output_points);
   assign rd_localerr = {7'h00, local_err};

   always_comb begin
      case (reg_addr)
         `MCESV_ADDR_CTRL: rd_mux = rd_ctrl;
         `MCESV_ADDR_STOPALL: rd_mux = rd_stopall;
         `MCESV_ADDR_STATUS: rd_mux = rd_status;
         `MCESV_ADDR_ERRCODE: rd_mux = err_code;
         `MCESV_ADDR_ERRCPU: rd_mux = rd_errcpu;
         `MCESV_ADDR_OUTPUTS: rd_mux = rd_outputs;
         `MCESV_ADDR_LOCALERR: rd_mux = rd_localerr;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end
endmodule

/* tb/mcesv_peer_model.sv */
// peer cpus on the shared backplane
`timescale 1ns/1ps
module mcesv_peer_model #(
   parameter int NCPU = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NCPU-1:0] fail_cmd,
   input wire logic [NCPU-1:0] reset_cmd,
   output logic [NCPU-1:0] peer_stop,
   output logic [NCPU-1:0] peer_in_reset
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         peer_stop <= '0;
         peer_in_reset <= '0;
      end else begin
         peer_stop <= peer_stop | fail_cmd;
         peer_in_reset <= reset_cmd;
      end
   end
endmodule

/* tb/mcesv_supervisor_bench.sv */
// self-checking bench for the multi-cpu error supervisor
`timescale 1ns/1ps
`include "mcesv_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mcesv_supervisor_bench;
   import mcesv_pkg::*;
   logic clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
   logic [1:0] self_id = 2'h1;
   logic [8:0] local_err = '0;
   logic [3:0] fail_cmd = '0, reset_cmd = '0, reg_addr = '0;
   logic [3:0] peer_stop, peer_in_reset;
   logic [15:0] prog_outputs = 16'hA5C3, reg_wdata = '0, reg_rdata;
   logic [15:0] actual_output_points;
   mcesv_code_t shared_err_code;
   logic self_stop, controller_ready_flag, program_halt, shared_err_valid;
   logic [1:0] shared_err_cpu;
   int error_cnt = 0, checks = 0, cyc = 0;
   mcesv_code_t exp_code [4] = '{`MCESV_CODE_PEER_HALT,
      `MCESV_CODE_PEER_HALT, `MCESV_CODE_PEER_HALT, `MCESV_CODE_LIST};
   always #5 clk = ~clk;
   mcesv_peer_model #(.NCPU(4)) mcesv_peer_model_i (.clk(clk),
      .rst_n(rst_n), .fail_cmd(fail_cmd), .reset_cmd(reset_cmd),
      .peer_stop(peer_stop), .peer_in_reset(peer_in_reset));
   mcesv_supervisor #(.NCPU(4), .NOUT(16)) mcesv_supervisor_i (.clk(clk),
      .rst_n(rst_n), .ce(ce), .self_id(self_id), .local_err(local_err),
      .peer_stop(peer_stop), .peer_in_reset(peer_in_reset),
      .prog_outputs(prog_outputs), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .self_stop(self_stop),
      .controller_ready_flag(controller_ready_flag),
      .actual_output_points(actual_output_points),
      .program_halt(program_halt), .shared_err_code(shared_err_code),
      .shared_err_cpu(shared_err_cpu), .shared_err_valid(shared_err_valid));
   task automatic test_done();
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      fail_cmd <= '0;
      reset_cmd <= '0;
      local_err <= '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   initial begin
      do_reset();
      rd(`MCESV_ADDR_STOPALL, 16'h000F);
      rd(4'hF, 16'h0000);
      @(posedge clk);
      ce <= 1'b0;
      wr(`MCESV_ADDR_CTRL, 16'h0001);
      ce <= 1'b1;
      step(3);
      `CHK(controller_ready_flag, 1'b0)
      wr(`MCESV_ADDR_CTRL, 16'h0001);
      step(3);
      `CHK(controller_ready_flag, 1'b1)
      `CHK(actual_output_points, 16'hA5C3)
      @(posedge clk);
      local_err <= 9'h008;
      prog_outputs <= 16'h1234;
      step(3);
      `CHK(program_halt, 1'b1)
      `CHK(actual_output_points, 16'hA5C3)
      @(posedge clk);
      local_err <= '0;
      step(3);
      `CHK(actual_output_points, 16'h1234)
      `CHK(program_halt, 1'b0)
      @(posedge clk);
      local_err <= 9'h002;
      step(3);
      `CHK(actual_output_points, 16'h0000)
      `CHK(controller_ready_flag, 1'b0)
      @(posedge clk);
      local_err <= '0;
      step(3);
      `CHK(controller_ready_flag, 1'b1)
      @(posedge clk);
      local_err <= 9'h100;
      step(3);
      `CHK(shared_err_code, `MCESV_CODE_LIST)
      `CHK(self_stop, 1'b0)
      @(posedge clk);
      local_err <= '0;
      wr(`MCESV_ADDR_STOPALL, 16'h000B);
      fail_cmd <= 4'h4;
      step(5);
      `CHK(shared_err_code, `MCESV_CODE_PEER_WARN)
      `CHK(shared_err_cpu, 2'h2)
      `CHK(controller_ready_flag, 1'b1)
      @(posedge clk);
      fail_cmd <= 4'hC;
      step(5);
      `CHK(shared_err_code, `MCESV_CODE_PEER_HALT)
      `CHK(shared_err_cpu, 2'd1)
      `CHK(shared_err_valid, 1'b1)
      `CHK(actual_output_points, 16'h0000)
      `CHK(controller_ready_flag, 1'b0)
      do_reset();
      step(1);
      `CHK(self_stop, 1'b0)
      rd(`MCESV_ADDR_ERRCODE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         do_reset();
         wr(`MCESV_ADDR_STOPALL, 16'h0000);
         wr(`MCESV_ADDR_CTRL, 16'h0001);
         step(3);
         @(posedge clk);
         case (i)
            0: fail_cmd <= 4'h1;
            1: reset_cmd <= 4'h8;
            2: local_err <= 9'h004;
            default: local_err <= 9'h104;
         endcase
         step(5);
         `CHK(self_stop, 1'b1)
         `CHK(shared_err_code, exp_code[i])
      end
      do_reset();
      local_err <= 9'h001;
      wr(`MCESV_ADDR_CTRL, 16'h0001);
      step(3);
      @(posedge clk);
      local_err <= '0;
      step(3);
      `CHK(controller_ready_flag, 1'b0)
      `CHK(actual_output_points, 16'h0000)
      rd(`MCESV_ADDR_STATUS, 16'h0002);
      test_done();
   end
endmodule

/* tb/mcesv_supervisor_properties.sv */
// assertions for the multi-cpu error supervisor
`timescale 1ns/1ps
`include "mcesv_consts.svh"
module mcesv_supervisor_properties
   import mcesv_pkg::*;
#(
   parameter int NCPU = 4,
   parameter int NOUT = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [1:0] self_id,
   input wire logic [8:0] local_err,
   input wire logic [NCPU-1:0] peer_stop,
   input wire logic [NCPU-1:0] peer_in_reset,
   input wire logic self_stop,
   input wire logic controller_ready_flag,
   input wire logic [NOUT-1:0] actual_output_points,
   input wire logic program_halt,
   input wire mcesv_pkg::mcesv_code_t shared_err_code,
   input wire logic shared_err_valid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_stop_outputs_off: assert property (self_stop |->
      actual_output_points == '0 && !controller_ready_flag)
      else $error("outputs or ready on while stopped");
   a_stop_stays_set: assert property (self_stop |=> self_stop)
      else $error("stop left without reset");
   a_wdt_outputs_off: assert property (ce && local_err[1] |=>
      actual_output_points == '0 && !controller_ready_flag)
      else $error("outputs on during watchdog timeout");
   a_setting_no_run: assert property (ce && local_err[0] |=>
      actual_output_points == '0 && !controller_ready_flag)
      else $error("running with setting error");
   a_cpu_one_halt: assert property ($rose(peer_stop[0]) && ce &&
      self_id != 2'h0 && controller_ready_flag |-> ##[1:3] self_stop)
      else $error("cpu one stop did not halt");
   a_peer_reset_halt: assert property ($rose(peer_in_reset[3]) &&
      ce && self_id != 2'h3 && controller_ready_flag |-> ##[1:3] self_stop)
      else $error("peer reset did not halt");
   a_halt_record_set: assert property ($rose(self_stop) |->
      shared_err_valid && (shared_err_code == `MCESV_CODE_PEER_HALT ||
      shared_err_code == `MCESV_CODE_LIST))
      else $error("stop without error record");
   a_warn_keeps_run: assert property ($changed(shared_err_code) &&
      shared_err_code == `MCESV_CODE_PEER_WARN |-> !self_stop)
      else $error("warning stopped the controller");
   a_cont_halts_prog: assert property (ce && (|local_err[7:3])
      |=> program_halt)
      else $error("continuable error without program halt");
endmodule
bind mcesv_supervisor mcesv_supervisor_properties #(.NCPU(NCPU),
   .NOUT(NOUT)) mcesv_supervisor_properties_i (.clk(clk), .rst_n(rst_n),
   .ce(ce), .self_id(self_id), .local_err(local_err),
   .peer_stop(peer_stop), .peer_in_reset(peer_in_reset),
   .self_stop(self_stop), .controller_ready_flag(controller_ready_flag),
   .actual_output_points(actual_output_points),
   .program_halt(program_halt), .shared_err_code(shared_err_code),
   .shared_err_valid(shared_err_valid));
